// [shared/qdc_pkg.sv]
// Purpose: constants, types and opcodes of the four-line flash host
// Assumes: mclk at 50 MHz, link clock made by divider
// Notes: register indices are word indices of the plain register port
package qdc_pkg;
  localparam int CLK_NS = 20;
  localparam int T_SCLK_NS = 160;
  localparam int HALF_DIV = T_SCLK_NS / (2 * CLK_NS);
  localparam int T_CSH_NS = 50;
  localparam int CSH_CYC = (T_CSH_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam logic [8:0] WRAP_LEN = 9'h004;
  localparam logic [8:0] WRAP_IDX = 9'h003;
  localparam logic [4:0] DUM_SPI_FAST = 5'h08;
  localparam logic [4:0] DUM_SPI_QIO = 5'h04;
  localparam logic [4:0] DUM_QPI_DEF = 5'h04;
  localparam logic [4:0] DUM_QPI_RDID = 5'h06;
  localparam logic [4:0] DUM_SPI_RDID = 5'h18;
  localparam logic [4:0] DUM_DTR = 5'h06;
  localparam logic [7:0] PARAM_RST = 8'h00;
  // Register indices
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_LEN = 4'h2;
  localparam logic [3:0] REG_MODE = 4'h3;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_PTR = 4'h5;
  localparam logic [3:0] REG_STAT = 4'h6;
  localparam int CTRL_SEC = 9;
  localparam int STAT_ERR = 2;
  // Lane and direction codes
  localparam logic [1:0] LN1 = 2'h0;
  localparam logic [1:0] LN2 = 2'h1;
  localparam logic [1:0] LN4 = 2'h2;
  localparam logic [1:0] DIR_NONE = 2'h0;
  localparam logic [1:0] DIR_WR = 2'h1;
  localparam logic [1:0] DIR_RD = 2'h2;
  // Opcodes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_VWREN = 8'h50;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_RDSR3 = 8'h15;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  localparam logic [7:0] OP_WRSR3 = 8'h11;
  localparam logic [7:0] OP_CE1 = 8'hc7;
  localparam logic [7:0] OP_CE2 = 8'h60;
  localparam logic [7:0] OP_SUS = 8'h75;
  localparam logic [7:0] OP_RES = 8'h7a;
  localparam logic [7:0] OP_PD = 8'hb9;
  localparam logic [7:0] OP_SETP = 8'hc0;
  localparam logic [7:0] OP_RDID = 8'hab;
  localparam logic [7:0] OP_MFID = 8'h90;
  localparam logic [7:0] OP_JEDEC = 8'h9f;
  localparam logic [7:0] OP_EN_QPI = 8'h38;
  localparam logic [7:0] OP_EX_QPI = 8'hff;
  localparam logic [7:0] OP_RSTEN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hd8;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FREAD = 8'h0b;
  localparam logic [7:0] OP_WRAPRD = 8'h0c;
  localparam logic [7:0] OP_QIOR = 8'heb;
  localparam logic [7:0] OP_WRAPSET = 8'h77;
  localparam logic [7:0] OP_SECER = 8'h44;
  localparam logic [7:0] OP_SECPG = 8'h42;
  localparam logic [7:0] OP_SECRD = 8'h48;
  localparam logic [7:0] OP_DTR_RD = 8'h0d;
  localparam logic [7:0] OP_DTR_DIO = 8'hbd;
  localparam logic [7:0] OP_DTR_QIO = 8'hed;
  localparam logic [7:0] OP_DTR_WRAP = 8'h0e;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADR, ST_MOD, ST_DUM, ST_WR, ST_RD, ST_END
  } qdc_st_e;

  typedef struct packed {
    logic ok;
    logic adr;
    logic mod;
    logic [1:0] dir;
    logic [4:0] dum;
    logic [1:0] la;
    logic [1:0] ld;
    logic dtr;
    logic write_enable_latch;
  } qdc_cfg_s;
endpackage : qdc_pkg

// [tb/qdc_flash_model.sv]
// Purpose: behavioural serial flash device seen by the host controller
// Assumes: sclk idles low; device samples on rising and drives on falling sclk
// Notes: decodes opcodes, framing mode, write latch and the repeating status read
`timescale 1ns/1ps
module qdc_flash_model (
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [7:0] last_op,
  output logic four_line,
  output logic write_enable_latch
);
  logic [7:0] sh;
  logic [5:0] nb;
  logic [5:0] ob;
  logic [7:0] st;
  logic [23:0] arg;
  logic [7:0] sr1;
  logic [7:0] sr2;
  logic [7:0] prm;
  logic [3:0] sec_sel;
  logic arm;
  assign st = {6'h00, write_enable_latch, 1'b0};
  // Status register 2 write; quad enable held while in four-line mode
  function automatic logic [7:0] sr2_wr(input logic [7:0] d);
    sr2_wr = four_line ? {d[7:2], sr2[1], d[0]} : d;
  endfunction : sr2_wr
  // Power-up state; quad enable set so four-line mode may be entered
  initial begin
    nb = 6'h00;
    ob = 6'h00;
    sh = 8'h00;
    arg = 24'h000000;
    sr1 = 8'h00;
    sr2 = 8'h02;
    prm = 8'h00;
    sec_sel = 4'h0;
    arm = 1'b0;
    last_op = 8'h00;
    four_line = 1'b0;
    write_enable_latch = 1'b0;
    io_out = 4'h5;
  end
  // Opcode, then up to three argument bytes, one lane or four lanes by framing mode
  always @(posedge sclk) if (!cs_n && nb < 6'h20) begin
    if (nb < 6'h08)
      sh = four_line ? {sh[3:0], io_in} : {sh[6:0], io_in[0]};
    else
      arg = four_line ? {arg[19:0], io_in} : {arg[22:0], io_in[0]};
    nb = nb + (four_line ? 6'h04 : 6'h01);
    if (nb == 6'h08) last_op = sh;
  end
  // Status byte repeats while selected; other reads see IO3 and IO1 high, IO2 and IO0 low
  always @(negedge sclk) if (!cs_n && nb >= 6'h08) begin
    if (last_op == 8'h05) begin
      io_out = four_line ? (ob[0] ? st[3:0] : st[7:4]) : {2'b00, st[3'h7 - ob[2:0]], 1'b0};
      ob = ob + 6'h01;
    end else begin
      io_out = 4'ha;
    end
  end
  // Frame end: act only on a whole opcode, then invert the output lanes
  always @(posedge cs_n) begin
    if (nb >= 6'h08) begin
      if (last_op == 8'h06) write_enable_latch = 1'b1;
      if (last_op == 8'h04) write_enable_latch = 1'b0;
      if (last_op == 8'h38) four_line = 1'b1;
      if (last_op == 8'hff) four_line = 1'b0;
      if (last_op == 8'hc0 && nb == 6'h10) prm = arg[7:0];
      if (last_op == 8'h48 && arg[23:16] == 8'h00 && arg[11:10] == 2'h0) begin
        sec_sel = arg[15:12];
      end
      if (write_enable_latch && last_op == 8'h01 && nb == 6'h18) begin
        sr1 = arg[15:8];
        sr2 = sr2_wr(arg[7:0]);
      end
      if (write_enable_latch && last_op == 8'h01 && nb == 6'h10) sr1 = arg[7:0];
      if (write_enable_latch && last_op == 8'h31 && nb == 6'h10) sr2 = sr2_wr(arg[7:0]);
      // Status writes 01 and 31 and page program 02 use up the write-enable latch
      if (last_op == 8'h01 || last_op == 8'h31 || last_op == 8'h02) write_enable_latch = 1'b0;
      if (last_op == 8'h99 && arm) begin
        four_line = 1'b0;
        write_enable_latch = 1'b0;
      end
      arm = last_op == 8'h66;
    end
    nb = 6'h00;
    ob = 6'h00;
    io_out = ~io_out;
  end
endmodule : qdc_flash_model

// [tb/qpi_dtr_command_decoder_bench.sv]
// Purpose: self-checking bench of the flash host over its register port
// Assumes: device model on the lanes; host makes the link clock
// Notes: each command waits for busy to clear under a bounded loop
`timescale 1ns/1ps
module qpi_dtr_command_decoder_bench;
  import qdc_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic cs_n;
  logic sclk;
  logic [3:0] io_o;
  logic [3:0] io_oe_n;
  logic [3:0] io_i;
  logic [3:0] dev_o;
  logic [7:0] m_op;
  logic m_quad;
  logic m_wel;
  logic [31:0] v;
  logic sec_bit = 1'b0;
  int n_fail = 0;
  int check_count = 0;
  // Lane level: host drive wins where enabled, else the device
  assign io_i = (~io_oe_n & io_o) | (io_oe_n & dev_o);
  always #10 mclk = ~mclk;
  qdc_host DUT (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cs_n(cs_n), .sclk(sclk), .io_o(io_o), .io_oe_n(io_oe_n), .io_i(io_i));
  qdc_flash_model flash (.cs_n(cs_n), .sclk(sclk), .io_in(io_o), .io_out(dev_o),
    .last_op(m_op), .four_line(m_quad), .write_enable_latch(m_wel));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // Start one command and wait until the host is idle again
  task automatic run_cmd(input logic [7:0] op, input logic [8:0] len);
    int i;
    wr_reg(REG_LEN, {23'h0, len});
    wr_reg(REG_CTRL, {22'h0, sec_bit, 1'b0, op});
    for (i = 0; i < 2000; i++) begin
      rd_reg(REG_STAT, v);
      if (v[0] === 1'b0) break;
    end
    if (i == 2000) begin
      n_fail++;
      final_report();
    end
    repeat (4) @(posedge mclk);
  endtask : run_cmd
  // Main sequence
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd_reg(REG_STAT, v);
    check(v, 32'h0);
    rd_reg(4'hf, v);
    check(v, 32'h0);
    wr_reg(REG_ADDR, 32'h00123456);
    rd_reg(REG_ADDR, v);
    check(v[23:0], 24'h123456);
    run_cmd(OP_WREN, 9'h001);
    check({m_op, m_wel}, {OP_WREN, 1'b1});
    check(v[3], 1'b1);
    run_cmd(OP_RDSR1, 9'h002);
    check(v[23:16], 8'h02);
    run_cmd(OP_EN_QPI, 9'h001);
    check({m_quad, v[1]}, 2'b11);
    run_cmd(OP_RDSR1, 9'h002);
    check({m_op, v[23:16]}, {OP_RDSR1, 8'h02});
    run_cmd(OP_PP, 9'h000);
    check({m_op, v[2]}, {OP_RDSR1, 1'b1});
    wr_reg(REG_STAT, 32'h4);
    rd_reg(REG_STAT, v);
    check(v[2], 1'b0);
    wr_reg(REG_PTR, 32'h0);
    wr_reg(REG_DATA, 32'h61);
    wr_reg(REG_DATA, 32'h5a);
    run_cmd(OP_SETP, 9'h001);
    check({m_op, v[15:8], flash.prm}, {OP_SETP, 8'h61, 8'h61});
    run_cmd(OP_WRSR2, 9'h001);
    check({m_op, flash.sr2}, {OP_WRSR2, 8'h63});
    run_cmd(OP_FREAD, 9'h002);
    check({m_op, v[23:16]}, {OP_FREAD, 8'haa});
    run_cmd(OP_WREN, 9'h001);
    run_cmd(OP_PP, 9'h002);
    check({m_op, v[3]}, {OP_PP, 1'b0});
    run_cmd(OP_QIOR, 9'h001);
    check({m_op, v[23:16]}, {OP_QIOR, 8'haa});
    run_cmd(OP_DTR_QIO, 9'h001);
    check({m_op, v[23:16]}, {OP_DTR_QIO, 8'haa});
    run_cmd(OP_WRDI, 9'h001);
    check({m_op, m_wel, v[3]}, {OP_WRDI, 2'b00});
    run_cmd(OP_RDSR1, 9'h002);
    check(v[23:16], 8'h00);
    run_cmd(OP_EX_QPI, 9'h001);
    check({m_op, m_quad, v[1]}, {OP_EX_QPI, 2'b00});
    run_cmd(OP_DTR_DIO, 9'h001);
    check({m_op, v[23:16]}, {OP_DTR_DIO, 8'haa});
    wr_reg(REG_ADDR, 32'h00002005);
    sec_bit = 1'b1;
    run_cmd(OP_SECRD, 9'h001);
    check({m_op, flash.sec_sel}, {OP_SECRD, 4'h2});
    wr_reg(REG_ADDR, 32'h00000005);
    run_cmd(OP_SECRD, 9'h001);
    check(v[2], 1'b1);
    sec_bit = 1'b0;
    wr_reg(REG_STAT, 32'h4);
    wr_reg(REG_PTR, 32'h0);
    wr_reg(REG_DATA, 32'h1c);
    wr_reg(REG_DATA, 32'h02);
    run_cmd(OP_WREN, 9'h001);
    run_cmd(OP_WRSR1, 9'h002);
    check({flash.sr1, flash.sr2, v[3]}, {16'h1c02, 1'b0});
    run_cmd(OP_WREN, 9'h001);
    run_cmd(OP_RSTEN, 9'h001);
    run_cmd(OP_RST, 9'h001);
    check({m_op, m_wel, v[3]}, {OP_RST, 2'b00});
    run_cmd(OP_SUS, 9'h001);
    check(m_op, OP_SUS);
    final_report();
  end
endmodule : qpi_dtr_command_decoder_bench

// [verilog/qdc_buf.sv]
// Purpose: 256-byte data buffer of the flash host
// Assumes: one write port, one read port, same clock
// Notes: read data come out of a register one cycle after the address
`timescale 1ns/1ps
module qdc_buf (
  input wire logic mclk,
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:255];

  // Write port
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge mclk) begin
    rdata <= mem[raddr];
  end
endmodule : qdc_buf

// [verilog/qdc_host.sv]
// Purpose: host controller driving a serial flash in single or four-line framing
// Assumes: link clock made here by dividing mclk; device keeps its own rules
// Notes: software loads ADDR, LEN, MODE and buffer, then writes CTRL to start
`timescale 1ns/1ps
module qdc_host
  import qdc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic cs_n,
  output logic sclk,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_n,
  input wire logic [3:0] io_i
);
  qdc_st_e st_r, st_nxt, ph_n;
  qdc_cfg_s cfg_r, cfg_new;
  logic [3:0] io_s1_r, io_s2_r, nb_r, lin;
  logic [7:0] op_r, mode_r, ptr_r, ptr_nxt, param_r, rx_r, sh_r, sh_sh, rxb, ld_b;
  logic [7:0] buf_dout, buf_wd, buf_wa, buf_ra;
  logic [23:0] adr_r, a_r;
  logic [8:0] len_r, lenx_r, bidx_r, wix;
  logic [4:0] dcnt_r;
  logic [2:0] wrap_r, gap_r, div_r;
  logic [1:0] abyte_r, ln;
  logic sec_r, qpi_r, err_r, wel_r, vwe_r, arm_r, sclk_r;
  logic tick, bdone, last, dum_end, load, dtrph, shifting, start, bad, fin, rd_we, sw_we;

  // Lane count code of a phase
  function automatic logic [1:0] ln_of(input qdc_st_e s, input qdc_cfg_s c, input logic q);
    if (s == ST_OPC) begin
      ln_of = q ? LN4 : LN1;
    end else if (s == ST_WR || s == ST_RD) begin
      ln_of = c.ld;
    end else begin
      ln_of = c.la;
    end
  endfunction : ln_of

  // Beats per byte for a lane count
  function automatic logic [3:0] beats(input logic [1:0] l);
    beats = 4'h8 >> l;
  endfunction : beats

  // Phase that follows s
  function automatic qdc_st_e nxt_ph(input qdc_st_e s, input qdc_cfg_s c);
    if (s == ST_OPC && c.adr) begin
      nxt_ph = ST_ADR;
    end else if ((s == ST_OPC || s == ST_ADR) && c.mod) begin
      nxt_ph = ST_MOD;
    end else if (s != ST_DUM && c.dum != 5'h00) begin
      nxt_ph = ST_DUM;
    end else if (c.dir == DIR_WR) begin
      nxt_ph = ST_WR;
    end else if (c.dir == DIR_RD) begin
      nxt_ph = ST_RD;
    end else begin
      nxt_ph = ST_END;
    end
  endfunction : nxt_ph

  // Opcode table: phases, lanes and dummy clocks
  function automatic qdc_cfg_s op_cfg(input logic [7:0] op, input logic q, input logic [7:0] p);
    qdc_cfg_s c;
    logic [4:0] pd;
    c = '0;
    pd = (p[7:4] == 4'h0) ? DUM_QPI_DEF : {1'b0, p[7:4]};
    c.ok = 1'b1;
    c.la = q ? LN4 : LN1;
    c.ld = c.la;
    case (op)
      OP_WREN, OP_VWREN, OP_WRDI, OP_RSTEN, OP_RST, OP_PD, OP_SUS, OP_RES: c.ok = 1'b1;
      OP_CE1, OP_CE2: c.write_enable_latch = 1'b1;
      OP_RDSR1, OP_RDSR2, OP_RDSR3, OP_JEDEC: c.dir = DIR_RD;
      OP_WRSR1, OP_WRSR2, OP_WRSR3: begin
        c.dir = DIR_WR;
        c.write_enable_latch = 1'b1;
      end
      OP_SE, OP_BE32, OP_BE64, OP_SECER: begin
        c.adr = 1'b1;
        c.write_enable_latch = 1'b1;
      end
      OP_PP, OP_SECPG: begin
        c.adr = 1'b1;
        c.dir = DIR_WR;
        c.write_enable_latch = 1'b1;
      end
      OP_FREAD, OP_WRAPRD: begin
        c.ok = q || op == OP_FREAD;
        c.adr = 1'b1;
        c.dum = q ? pd : DUM_SPI_FAST;
        c.dir = DIR_RD;
      end
      OP_SECRD: begin
        c.adr = 1'b1;
        c.dum = DUM_SPI_FAST;
        c.dir = DIR_RD;
      end
      OP_READ, OP_MFID: begin
        c.ok = (op == OP_READ) ? !q : q;
        c.adr = 1'b1;
        c.dir = DIR_RD;
      end
      OP_RDID: begin
        c.dum = q ? DUM_QPI_RDID : DUM_SPI_RDID;
        c.dir = DIR_RD;
      end
      OP_EN_QPI: c.ok = !q;
      OP_EX_QPI: c.ok = q;
      OP_SETP: begin
        c.ok = q;
        c.dir = DIR_WR;
      end
      OP_QIOR: begin
        c.adr = 1'b1;
        c.mod = 1'b1;
        c.la = LN4;
        c.ld = LN4;
        c.dum = q ? pd : DUM_SPI_QIO;
        c.dir = DIR_RD;
      end
      OP_WRAPSET: begin
        c.ok = !q;
        c.dir = DIR_WR;
        c.ld = LN4;
      end
      OP_DTR_RD, OP_DTR_DIO, OP_DTR_QIO, OP_DTR_WRAP: begin
        c.ok = (op == OP_DTR_DIO) ? !q : (op != OP_DTR_WRAP || q);
        c.adr = 1'b1;
        c.mod = op == OP_DTR_DIO || op == OP_DTR_QIO;
        c.dtr = 1'b1;
        c.dum = DUM_DTR;
        c.dir = DIR_RD;
        if (!q && op == OP_DTR_DIO) begin
          c.la = LN2;
        end else if (!q && op == OP_DTR_QIO) begin
          c.la = LN4;
        end
        c.ld = c.la;
      end
      default: c.ok = 1'b0;
    endcase
    op_cfg = c;
  endfunction : op_cfg

  // Two-flop synchroniser for the data lines
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
    end else begin
      io_s1_r <= io_i;
      io_s2_r <= io_s1_r;
    end
  end

  // Beat timing, shifting and phase decisions
  always_comb begin
    ln = ln_of(st_r, cfg_r, qpi_r);
    dtrph = cfg_r.dtr && st_r != ST_OPC;
    shifting = st_r inside {ST_OPC, ST_ADR, ST_MOD, ST_WR, ST_RD};
    tick = st_r != ST_IDLE && st_r != ST_END && div_r == 3'(HALF_DIV - 1);
    bdone = tick && shifting && (sclk_r || dtrph);
    last = bdone && nb_r == 4'h1;
    case (ln)
      LN1: lin = {3'h0, io_s2_r[1]};
      LN2: lin = {2'h0, io_s2_r[1:0]};
      default: lin = io_s2_r;
    endcase
    sh_sh = sh_r << (3'h1 << ln);
    rxb = sh_sh | {4'h0, lin};
    wix = (st_r == ST_WR) ? bidx_r : 9'h000;
    ph_n = st_r;
    if (st_r == ST_DUM) begin
      if (tick && sclk_r && dcnt_r == 5'h01) begin
        ph_n = nxt_ph(st_r, cfg_r);
      end
    end else if (last) begin
      case (st_r)
        ST_ADR: ph_n = (abyte_r == 2'h2) ? nxt_ph(st_r, cfg_r) : ST_ADR;
        ST_WR: ph_n = (bidx_r == lenx_r) ? ST_END : ST_WR;
        ST_RD: ph_n = (9'(bidx_r + 9'h001) == lenx_r) ? ST_END : ST_RD;
        default: ph_n = nxt_ph(st_r, cfg_r);
      endcase
    end
    dum_end = st_r == ST_DUM && ph_n != ST_DUM;
    load = last || dum_end;
    fin = ph_n == ST_END && st_r != ST_END;
    case (ph_n)
      ST_ADR: begin
        case ((st_r == ST_ADR) ? 2'(abyte_r + 2'h1) : 2'h0)
          2'h0: ld_b = a_r[23:16];
          2'h1: ld_b = a_r[15:8];
          default: ld_b = a_r[7:0];
        endcase
      end
      ST_MOD: ld_b = cfg_r.dtr ? {4'hf, mode_r[3:0]} : mode_r;
      ST_WR: begin
        if (op_r == OP_WRAPSET) begin
          ld_b = (wix == WRAP_IDX) ? {1'b0, wrap_r, 4'h0} : 8'h00;
        end else begin
          ld_b = buf_dout;
        end
      end
      default: ld_b = 8'h00;
    endcase
  end

  // Command acceptance checks
  always_comb begin
    cfg_new = op_cfg(wdata[7:0], qpi_r, param_r);
    start = wr && addr == REG_CTRL;
    bad = !cfg_new.ok;
    if (cfg_new.write_enable_latch && !wel_r && !(vwe_r && cfg_new.dir == DIR_WR && !cfg_new.adr)) begin
      bad = 1'b1;
    end
    if (cfg_new.dir != DIR_NONE && wdata[7:0] != OP_WRAPSET &&
        (len_r == 9'h000 || len_r > PAGE_BYTES)) begin
      bad = 1'b1;
    end
    if (wdata[CTRL_SEC] && adr_r[13:12] == 2'h0) begin
      bad = 1'b1;
    end
    st_nxt = ph_n;
    if (st_r == ST_IDLE) begin
      st_nxt = (start && !bad) ? ST_OPC : ST_IDLE;
    end else if (st_r == ST_END) begin
      st_nxt = (gap_r == 3'h0) ? ST_IDLE : ST_END;
    end
    ptr_nxt = ptr_r;
    if (wr && addr == REG_PTR) begin
      ptr_nxt = wdata[7:0];
    end else if (st_r == ST_IDLE && (wr || rd) && addr == REG_DATA) begin
      ptr_nxt = 8'(ptr_r + 8'h01);
    end
    rd_we = last && st_r == ST_RD;
    sw_we = wr && addr == REG_DATA && st_r == ST_IDLE;
    buf_wa = rd_we ? bidx_r[7:0] : ptr_r;
    buf_wd = rd_we ? rxb : wdata[7:0];
    buf_ra = (st_r == ST_IDLE) ? ptr_nxt : bidx_r[7:0];
  end

  // Frame state, link clock divider and chip select
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      div_r <= 3'h0;
      sclk_r <= 1'b0;
      cs_n <= 1'b1;
      sclk <= 1'b0;
      gap_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      div_r <= (st_nxt == ST_IDLE || st_nxt == ST_END || tick) ? 3'h0 : 3'(div_r + 3'h1);
      sclk_r <= (st_nxt == ST_IDLE || st_nxt == ST_END) ? 1'b0 : sclk_r ^ tick;
      sclk <= (st_nxt == ST_IDLE || st_nxt == ST_END) ? 1'b0 : sclk_r ^ tick;
      cs_n <= st_nxt == ST_IDLE || st_nxt == ST_END;
      gap_r <= fin ? 3'(CSH_CYC - 1) : 3'(gap_r - (gap_r != 3'h0));
    end
  end

  // Shift register, beat and byte counters
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sh_r <= 8'h00;
      nb_r <= 4'h0;
      abyte_r <= 2'h0;
      bidx_r <= 9'h000;
      dcnt_r <= 5'h00;
      rx_r <= 8'h00;
    end else if (st_r == ST_IDLE) begin
      sh_r <= wdata[7:0];
      nb_r <= beats(qpi_r ? LN4 : LN1);
      abyte_r <= 2'h0;
      bidx_r <= 9'h000;
    end else begin
      if (load) begin
        sh_r <= ld_b;
        nb_r <= beats(ln_of(ph_n, cfg_r, qpi_r));
      end else if (bdone) begin
        sh_r <= (st_r == ST_RD) ? rxb : sh_sh;
        nb_r <= 4'(nb_r - 4'h1);
      end
      if (last && st_r == ST_ADR) begin
        abyte_r <= 2'(abyte_r + 2'h1);
      end
      if (load && ph_n == ST_WR) begin
        bidx_r <= 9'(wix + 9'h001);
      end else if (rd_we) begin
        bidx_r <= 9'(bidx_r + 9'h001);
        rx_r <= rxb;
      end
      if (load && ph_n == ST_DUM) begin
        dcnt_r <= cfg_r.dum;
      end else if (st_r == ST_DUM && tick && sclk_r) begin
        dcnt_r <= 5'(dcnt_r - 5'h01);
      end
    end
  end

  // Lane drivers: low enable while the host drives
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      io_o <= 4'h0;
      io_oe_n <= 4'hf;
    end else begin
      case (ln)
        LN1: io_o <= {3'h0, sh_r[7]};
        LN2: io_o <= {2'h0, sh_r[7:6]};
        default: io_o <= sh_r[7:4];
      endcase
      if (st_r inside {ST_OPC, ST_ADR, ST_MOD, ST_WR}) begin
        io_oe_n <= (ln == LN1) ? 4'he : ((ln == LN2) ? 4'hc : 4'h0);
      end else begin
        io_oe_n <= 4'hf;
      end
    end
  end

  // Command registers captured at start
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      op_r <= 8'h00;
      sec_r <= 1'b0;
      cfg_r <= '0;
      a_r <= 24'h000000;
      lenx_r <= 9'h000;
      err_r <= 1'b0;
    end else begin
      if (st_r == ST_IDLE && start && !bad) begin
        op_r <= wdata[7:0];
        sec_r <= wdata[CTRL_SEC];
        cfg_r <= cfg_new;
        a_r <= wdata[CTRL_SEC] ? {10'h000, adr_r[13:12], 2'h0, adr_r[9:0]} : adr_r;
        lenx_r <= (wdata[7:0] == OP_WRAPSET) ? WRAP_LEN : len_r;
      end
      if (start && (st_r != ST_IDLE || bad)) begin
        err_r <= 1'b1;
      end else if (wr && addr == REG_STAT && wdata[STAT_ERR]) begin
        err_r <= 1'b0;
      end
    end
  end

  // Software registers and read-back
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      adr_r <= 24'h000000;
      len_r <= 9'h000;
      mode_r <= 8'h00;
      wrap_r <= 3'h0;
      ptr_r <= 8'h00;
      rdata <= 32'h00000000;
    end else begin
      ptr_r <= ptr_nxt;
      if (wr && addr == REG_ADDR) begin
        adr_r <= wdata[23:0];
      end
      if (wr && addr == REG_LEN) begin
        len_r <= wdata[8:0];
      end
      if (wr && addr == REG_MODE) begin
        mode_r <= wdata[7:0];
        wrap_r <= wdata[10:8];
      end
      rdata <= 32'h00000000;
      if (rd) begin
        case (addr)
          REG_CTRL: rdata <= {22'h0, sec_r, 1'b0, op_r};
          REG_ADDR: rdata <= {8'h00, adr_r};
          REG_LEN: rdata <= {23'h0, len_r};
          REG_MODE: rdata <= {21'h0, wrap_r, mode_r};
          REG_DATA: rdata <= {24'h0, buf_dout};
          REG_PTR: rdata <= {24'h0, ptr_r};
          REG_STAT: rdata <= {8'h00, rx_r, param_r, 4'h0, wel_r, err_r, qpi_r, st_r != ST_IDLE};
          default: rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Shadow of the device's mode, latch and read parameters
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      qpi_r <= 1'b0;
      wel_r <= 1'b0;
      vwe_r <= 1'b0;
      arm_r <= 1'b0;
      param_r <= PARAM_RST;
    end else begin
      if (load && ph_n == ST_WR && op_r == OP_SETP && wix == 9'h000) begin
        param_r <= buf_dout;
      end
      if (fin) begin
        arm_r <= op_r == OP_RSTEN;
        case (op_r)
          OP_WREN: wel_r <= 1'b1;
          OP_VWREN: vwe_r <= 1'b1;
          OP_WRDI: wel_r <= 1'b0;
          OP_EN_QPI: qpi_r <= 1'b1;
          OP_EX_QPI: qpi_r <= 1'b0;
          OP_RST: begin
            if (arm_r) begin
              qpi_r <= 1'b0;
              wel_r <= 1'b0;
              vwe_r <= 1'b0;
              param_r <= PARAM_RST;
            end
          end
          default: ;
        endcase
        if (cfg_r.write_enable_latch) begin
          wel_r <= 1'b0;
          vwe_r <= 1'b0;
        end
      end
    end
  end

  qdc_buf u_buf (
    .mclk(mclk),
    .we(rd_we || sw_we),
    .waddr(buf_wa),
    .wdata(buf_wd),
    .raddr(buf_ra),
    .rdata(buf_dout)
  );

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_frame_end;
    $rose(cs_n);
  endsequence
  sequence s_adr_start;
    $rose(st_r == ST_ADR);
  endsequence

  a_opc_quad: assert property ($fell(cs_n) && qpi_r |-> ##1 io_oe_n == 4'h0)
    else $error("four-line opcode not on all lanes");
  a_msb_first: assert property ($fell(cs_n) && !qpi_r |-> ##1 io_o[0] == op_r[7])
    else $error("opcode not sent msb first");
  a_quad_adr: assert property (s_adr_start ##0 cfg_r.la == LN4 |-> ##1 io_o == a_r[23:20])
    else $error("quad address nibble order wrong");
  a_dual_adr: assert property (s_adr_start ##0 cfg_r.la == LN2 |-> ##1 io_o[1:0] == a_r[23:22])
    else $error("dual address bit order wrong");
  a_page_len: assert property (st_r == ST_WR |-> lenx_r != 9'h000 && lenx_r <= PAGE_BYTES)
    else $error("program length out of range");
  a_sec_addr: assert property (st_r == ST_ADR && sec_r |-> a_r[23:16] == 8'h00 &&
                               a_r[11:10] == 2'h0 && a_r[15:12] != 4'h0)
    else $error("security address malformed");
  a_dum_param: assert property ($rose(st_r == ST_DUM) && qpi_r && op_r == OP_FREAD |->
      dcnt_r == ((param_r[7:4] == 4'h0) ? DUM_QPI_DEF : {1'b0, param_r[7:4]}))
    else $error("dummy count not from read parameter");
  a_mode_f: assert property ($rose(st_r == ST_MOD) && cfg_r.dtr |-> sh_r[7:4] == 4'hf)
    else $error("double-rate mode nibble not F");
  a_wel_first: assert property ($fell(cs_n) && cfg_r.write_enable_latch && cfg_r.adr |-> wel_r)
    else $error("modifying command without write enable");
  a_cs_gap: assert property (s_frame_end |-> cs_n [*3])
    else $error("chip select high time too short");
endmodule : qdc_host
